// ### common/vcm_pkg.sv
// package: register map, field positions, reset values for the comparator logic
package vcm_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [3:0] CONTROL_OFF = 4'h0;
   localparam logic [3:0] MODE_OFF = 4'h4;
   localparam logic [3:0] RESET_SRC_OFF = 4'h8;
   // ****************************************
   // control register fields
   // ****************************************
   localparam int EN_BIT = 7;
   localparam int LEVEL_BIT = 6;
   localparam int RISE_BIT = 5;
   localparam int FALL_BIT = 4;
   localparam int HYP_LSB = 2;
   localparam int HYN_LSB = 0;
   // ****************************************
   // mode register fields
   // ****************************************
   localparam int RIE_BIT = 5;
   localparam int FIE_BIT = 4;
   localparam int SPEED_LSB = 0;
   localparam logic [1:0] SPEED_RST = 2'h2;
   localparam logic [1:0] HYST_RST = 2'h0;
   // ****************************************
   // bus responses
   // ****************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### src/vcm_sync2.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module vcm_sync2 (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic meta;
      logic sync;
   } vcm_sync_t;
   vcm_sync_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (ce_i) begin
         s_d.meta = d_i;
         s_d.sync = s_q.meta;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign q_o = s_q.sync;
endmodule // vcm_sync2

// ### src/vcm_edge_flag.sv
// sticky edge flag with set-over-clear priority
`timescale 1ns/1ns
module vcm_edge_flag (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic clr_i,
   input wire logic irq_en_i,
   output logic flag_o,
   output logic req_o
);
   typedef struct packed {
      logic flag;
   } vcm_flag_t;
   vcm_flag_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (ce_i) begin
         if (set_i) begin
            s_d.flag = 1'b1;
         end else if (clr_i) begin
            s_d.flag = 1'b0;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign flag_o = s_q.flag;
   assign req_o = s_q.flag & irq_en_i;
   a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && set_i |=> flag_o)
      else $error("edge lost against clear");
   a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      flag_o && !(ce_i && clr_i) |=> flag_o)
      else $error("flag dropped without clear");
endmodule // vcm_edge_flag

// ### src/vcm_top.sv
// comparator control logic: axi4-lite registers, edge flags, outputs
// ****************************************
// Behaviour
// - two outputs: clock-synchronised latched output and raw unsynchronised output
// - raw output follows comparator without any clock, even in stop
// - disabled comparator drives both outputs low and powers core down
// - falling transition of output sets the falling flag
// - rising transition of output sets the rising flag
// - flags stay set until software writes them clear
// - interrupts possible on rising and falling edges, separately governed
// - rising flag requests interrupt only when its enable is one
// - falling flag requests interrupt only when its enable is one
// - level bit reads present output level, no side effects
// - enable bit one turns comparator on, zero turns it off
// - low four control bits hold positive and negative hysteresis codes
// - mode register holds response-time setting; slower saves supply current
// - comparator output selectable as device reset source
// - control: enable 7, level 6, rise 5, fall 4, reset zero
// - mode: rise enable 5, fall enable 4, speed 1:0 resets 10
// - speed 00 fastest highest power through 11 slowest lowest power
// ****************************************
`timescale 1ns/1ns
module vcm_top (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   // axi4-lite slave
   input wire logic [3:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [3:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // analog core side
   input wire logic CMP_DECISION_I,
   output logic CMP_POWER_EN_O,
   output logic [1:0] CMP_POS_HYST_O,
   output logic [1:0] CMP_NEG_HYST_O,
   output logic [1:0] CMP_SPEED_SEL_O,
   // crossbar and system
   output logic CMP_SYNC_OUT_O,
   output logic CMP_RAW_OUT_O,
   output logic CMP_IRQ_O,
   output logic CMP_RESET_REQ_O
);
   typedef struct packed {
      logic aw_got;
      logic [3:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic enable;
      logic [1:0] pos_hyst;
      logic [1:0] neg_hyst;
      logic rise_irq_en;
      logic fall_irq_en;
      logic [1:0] speed;
      logic rst_src_en;
      logic level_prev;
      logic sync_out;
      logic irq;
      logic rst_req;
      logic aw_ready;
      logic w_ready;
      logic ar_ready;
   } vcm_state_t;
   vcm_state_t s_q, s_d;

   logic level_sync;
   logic rise_flag, fall_flag, rise_req, fall_req;
   logic wr_fire, rd_fire, clr_rise, clr_fall;
   logic rise_evt, fall_evt;
   logic raw_out;

   // ****************************************
   // comparator level into clock domain
   // ****************************************
   vcm_sync2 u_sync (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .d_i(CMP_DECISION_I),
      .q_o(level_sync)
   );

   // compare against previous synchronised sample; gated off while disabled
   assign rise_evt = CE_I & s_q.enable & level_sync & ~s_q.level_prev;
   assign fall_evt = CE_I & s_q.enable & ~level_sync & s_q.level_prev;

   assign wr_fire = CE_I & s_q.aw_got & s_q.w_got & ~s_q.bvalid;
   assign rd_fire = CE_I & ARVALID_I & ~s_q.rvalid;
   // writing zero to a flag bit clears it; writing one keeps it
   assign clr_rise = wr_fire & (s_q.aw_addr == vcm_pkg::CONTROL_OFF) & s_q.w_strb[0]
                     & ~s_q.w_data[vcm_pkg::RISE_BIT];
   assign clr_fall = wr_fire & (s_q.aw_addr == vcm_pkg::CONTROL_OFF) & s_q.w_strb[0]
                     & ~s_q.w_data[vcm_pkg::FALL_BIT];

   // ****************************************
   // sticky edge flags
   // ****************************************
   vcm_edge_flag u_rise (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .set_i(rise_evt),
      .clr_i(clr_rise),
      .irq_en_i(s_q.rise_irq_en),
      .flag_o(rise_flag),
      .req_o(rise_req)
   );
   vcm_edge_flag u_fall (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .set_i(fall_evt),
      .clr_i(clr_fall),
      .irq_en_i(s_q.fall_irq_en),
      .flag_o(fall_flag),
      .req_o(fall_req)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      if (CE_I) begin
         if (AWVALID_I && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = AWADDR_I;
         end
         if (WVALID_I && !s_q.w_got) begin
            s_d.w_got = 1'b1;
            s_d.w_data = WDATA_I;
            s_d.w_strb = WSTRB_I;
         end
         if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = vcm_pkg::RESP_OKAY;
            unique case (s_q.aw_addr)
               vcm_pkg::CONTROL_OFF: begin
                  if (s_q.w_strb[0]) begin
                     s_d.enable = s_q.w_data[vcm_pkg::EN_BIT];
                     s_d.pos_hyst = s_q.w_data[vcm_pkg::HYP_LSB +: 2];
                     s_d.neg_hyst = s_q.w_data[vcm_pkg::HYN_LSB +: 2];
                  end
               end
               vcm_pkg::MODE_OFF: begin
                  if (s_q.w_strb[0]) begin
                     s_d.rise_irq_en = s_q.w_data[vcm_pkg::RIE_BIT];
                     s_d.fall_irq_en = s_q.w_data[vcm_pkg::FIE_BIT];
                     s_d.speed = s_q.w_data[vcm_pkg::SPEED_LSB +: 2];
                  end
               end
               vcm_pkg::RESET_SRC_OFF: begin
                  if (s_q.w_strb[0]) begin
                     s_d.rst_src_en = s_q.w_data[0];
                  end
               end
               default: begin
                  s_d.bresp = vcm_pkg::RESP_SLVERR;
               end
            endcase
         end
         if (s_q.bvalid && BREADY_I) begin
            s_d.bvalid = 1'b0;
         end
         if (s_q.rvalid && RREADY_I) begin
            s_d.rvalid = 1'b0;
         end
         if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = vcm_pkg::RESP_OKAY;
            s_d.rdata = '0;
            unique case (ARADDR_I)
               vcm_pkg::CONTROL_OFF: begin
                  s_d.rdata[vcm_pkg::EN_BIT] = s_q.enable;
                  s_d.rdata[vcm_pkg::LEVEL_BIT] = s_q.sync_out;
                  s_d.rdata[vcm_pkg::RISE_BIT] = rise_flag;
                  s_d.rdata[vcm_pkg::FALL_BIT] = fall_flag;
                  s_d.rdata[vcm_pkg::HYP_LSB +: 2] = s_q.pos_hyst;
                  s_d.rdata[vcm_pkg::HYN_LSB +: 2] = s_q.neg_hyst;
               end
               vcm_pkg::MODE_OFF: begin
                  s_d.rdata[vcm_pkg::RIE_BIT] = s_q.rise_irq_en;
                  s_d.rdata[vcm_pkg::FIE_BIT] = s_q.fall_irq_en;
                  s_d.rdata[vcm_pkg::SPEED_LSB +: 2] = s_q.speed;
               end
               vcm_pkg::RESET_SRC_OFF: begin
                  s_d.rdata[0] = s_q.rst_src_en;
               end
               default: begin
                  s_d.rresp = vcm_pkg::RESP_SLVERR;
               end
            endcase
         end
         // previous sample held low while disabled, so a high level at re-enable wakeup flags a rising edge
         s_d.level_prev = s_q.enable & level_sync;
         s_d.sync_out = s_q.enable & level_sync;
         s_d.irq = rise_req | fall_req;
         s_d.rst_req = s_q.rst_src_en & s_q.enable & ~level_sync;
         // ready flags kept as flops so the bus outputs need no gate
         s_d.aw_ready = ~s_d.aw_got;
         s_d.w_ready = ~s_d.w_got;
         s_d.ar_ready = ~s_d.rvalid;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_q <= '0;
         s_q.speed <= vcm_pkg::SPEED_RST;
         s_q.pos_hyst <= vcm_pkg::HYST_RST;
         s_q.neg_hyst <= vcm_pkg::HYST_RST;
         s_q.aw_ready <= 1'b1;
         s_q.w_ready <= 1'b1;
         s_q.ar_ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // raw path: pure gating with no clock, so it keeps working in stop;
   // the one output not from a flop, since a flop would need the clock
   always_comb begin
      raw_out = CMP_DECISION_I & s_q.enable & RST_N_I;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign AWREADY_O = s_q.aw_ready;
   assign WREADY_O = s_q.w_ready;
   assign BVALID_O = s_q.bvalid;
   assign BRESP_O = s_q.bresp;
   assign ARREADY_O = s_q.ar_ready;
   assign RVALID_O = s_q.rvalid;
   assign RRESP_O = s_q.rresp;
   assign RDATA_O = s_q.rdata;
   assign CMP_POWER_EN_O = s_q.enable;
   assign CMP_POS_HYST_O = s_q.pos_hyst;
   assign CMP_NEG_HYST_O = s_q.neg_hyst;
   assign CMP_SPEED_SEL_O = s_q.speed;
   assign CMP_SYNC_OUT_O = s_q.sync_out;
   assign CMP_RAW_OUT_O = raw_out;
   assign CMP_IRQ_O = s_q.irq;
   assign CMP_RESET_REQ_O = s_q.rst_req;

   // ****************************************
   // checks
   // ****************************************
   a_rise_sets: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && s_q.enable && level_sync && !s_q.level_prev |=> rise_flag)
      else $error("rising edge not flagged");
   a_fall_sets: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && s_q.enable && !level_sync && s_q.level_prev |=> fall_flag)
      else $error("falling edge not flagged");
   a_irq_gating: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I |=> CMP_IRQ_O ==
      $past((rise_flag & s_q.rise_irq_en) | (fall_flag & s_q.fall_irq_en)))
      else $error("interrupt does not match flags and enables");
   a_off_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CE_I && !s_q.enable |=> !CMP_SYNC_OUT_O)
      else $error("sync output high while disabled");
   a_raw_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !s_q.enable |-> !CMP_RAW_OUT_O && !CMP_POWER_EN_O)
      else $error("raw output or power on while disabled");
   a_level_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      rd_fire && ARADDR_I == vcm_pkg::CONTROL_OFF |=>
      RDATA_O[vcm_pkg::LEVEL_BIT] == $past(s_q.sync_out))
      else $error("level bit read wrong");
   a_no_edge_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !s_q.enable && !rise_flag ##1 !s_q.enable |-> !rise_flag)
      else $error("edge flagged while disabled");
   a_freeze: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !CE_I |=> $stable(s_q))
      else $error("state moved with clock enable low");
   c_rise: cover property (@(posedge CLK_I) disable iff (!RST_N_I) rise_evt);
   c_fall: cover property (@(posedge CLK_I) disable iff (!RST_N_I) fall_evt);
   c_irq: cover property (@(posedge CLK_I) disable iff (!RST_N_I) CMP_IRQ_O);
   c_set_clr: cover property (@(posedge CLK_I) disable iff (!RST_N_I) rise_evt && clr_rise);
endmodule // vcm_top

// ### verif/vcm_core_model.sv
// behavioural model of the analog comparator core
`timescale 1ns/1ns
module vcm_core_model (
   input wire logic clk_i,
   input wire logic power_en_i,
   input wire logic level_i,
   input wire logic slow_i,
   output logic decision_o
);
   // ********
   // decision path
   // ********
   logic junk_q = 1'b0;
   logic [2:0] dly_q = 3'h0;
   always @(posedge clk_i) begin
      junk_q <= ~junk_q;
      dly_q <= {dly_q[1:0], level_i};
   end
   // unpowered core has no valid decision: changing pattern, never a held level
   // slow mode lags three cycles, like the low-power response settings
   assign decision_o = !power_en_i ? junk_q : (slow_i ? dly_q[2] : level_i);
endmodule // vcm_core_model

// ### verif/comparator_edge_event_logic_test.sv
// self-checking bench for the comparator control logic
`timescale 1ns/1ns
module comparator_edge_event_logic_test;
   logic clk, rst_n, ce, lvl, slow, decision, pwr, sync_o, raw_o, irq, rst_req;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdata_v;
   logic [1:0] bresp, rresp, resp_v, physt, nhyst, speed;
   int errors, comparisons;
   vcm_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .AWADDR_I(awaddr),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf),
      .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
      .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
      .CMP_DECISION_I(decision), .CMP_POWER_EN_O(pwr), .CMP_POS_HYST_O(physt),
      .CMP_NEG_HYST_O(nhyst), .CMP_SPEED_SEL_O(speed), .CMP_SYNC_OUT_O(sync_o),
      .CMP_RAW_OUT_O(raw_o), .CMP_IRQ_O(irq), .CMP_RESET_REQ_O(rst_req));
   vcm_core_model core (.clk_i(clk), .power_en_i(pwr), .level_i(lvl), .slow_i(slow),
      .decision_o(decision));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ********
   // bus and compare tasks
   // ********
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bit aw_ok;
      bit w_ok;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 0;
      w_ok = 0;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk);
      resp_v = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      rdata_v = rdata;
      resp_v = rresp;
      rready <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
      rd(a);
      chk("read data", e, rdata_v);
      chk("read resp", {30'h0, vcm_pkg::RESP_OKAY}, {30'h0, resp_v});
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ********
   // tests
   // ********
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      {lvl, slow, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata} = 40'h0;
      errors = 0;
      comparisons = 0;
      wait_clk(2);
      rst_n <= 1'b1;
      rdchk(4'h0, 32'h00);
      rdchk(4'h4, 32'h02);
      chk("speed reset", 32'h2, {30'h0, speed});
      lvl <= 1'b1;
      wait_clk(4);
      chk("raw off", 32'h0, {31'h0, raw_o});
      chk("sync off", 32'h0, {31'h0, sync_o});
      chk("power off", 32'h0, {31'h0, pwr});
      $display("test reset done");
      lvl <= 1'b0;
      wr(4'h0, 32'h80);
      chk("power on", 32'h1, {31'h0, pwr});
      wait_clk(4);
      // junk from the unpowered core may leave a false edge: clear it first
      wr(4'h0, 32'h80);
      wait_clk(4);
      rdchk(4'h0, 32'h80);
      lvl <= 1'b1;
      #10 chk("raw follows", 32'h1, {31'h0, raw_o});
      wait_clk(5);
      chk("sync high", 32'h1, {31'h0, sync_o});
      rdchk(4'h0, 32'he0);
      rdchk(4'h0, 32'he0);
      chk("irq masked", 32'h0, {31'h0, irq});
      slow <= 1'b1;
      lvl <= 1'b0;
      wait_clk(8);
      rdchk(4'h0, 32'hb0);
      $display("test edges done");
      wr(4'h4, 32'h12);
      wait_clk(3);
      chk("irq fall", 32'h1, {31'h0, irq});
      wr(4'h0, 32'ha0);
      wait_clk(3);
      chk("irq rise masked", 32'h0, {31'h0, irq});
      wr(4'h4, 32'h22);
      wait_clk(3);
      chk("irq rise", 32'h1, {31'h0, irq});
      wr(4'h0, 32'h80);
      wait_clk(3);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rdchk(4'h0, 32'h80);
      $display("test interrupts done");
      for (int i = 0; i < 4; i++) begin
         wr(4'h4, 32'(i));
         rdchk(4'h4, 32'(i));
         chk("speed", 32'(i), {30'h0, speed});
         wr(4'h0, 32'h80 | 32'(i * 4) | 32'(3 - i));
         rdchk(4'h0, 32'h80 | 32'(i * 4) | 32'(3 - i));
         chk("pos hyst", 32'(i), {30'h0, physt});
         chk("neg hyst", 32'(3 - i), {30'h0, nhyst});
      end
      $display("test settings done");
      wr(4'h8, 32'h1);
      chk("write resp", {30'h0, vcm_pkg::RESP_OKAY}, {30'h0, resp_v});
      wait_clk(3);
      chk("reset req low level", 32'h1, {31'h0, rst_req});
      lvl <= 1'b1;
      wait_clk(8);
      chk("reset req high level", 32'h0, {31'h0, rst_req});
      wr(4'h8, 32'h0);
      rd(4'hc);
      chk("unmapped read data", 32'h0, rdata_v);
      chk("unmapped read resp", {30'h0, vcm_pkg::RESP_SLVERR}, {30'h0, resp_v});
      wr(4'hc, 32'hff);
      chk("unmapped write resp", {30'h0, vcm_pkg::RESP_SLVERR}, {30'h0, resp_v});
      $display("test reset source and map done");
      // clock enable low: latched side frozen, raw side still follows
      ce <= 1'b0;
      lvl <= 1'b0;
      wait_clk(10);
      chk("frozen sync", 32'h1, {31'h0, sync_o});
      chk("raw while frozen", 32'h0, {31'h0, raw_o});
      ce <= 1'b1;
      wait_clk(10);
      chk("thawed sync", 32'h0, {31'h0, sync_o});
      rdchk(4'h0, 32'hbc);
      $display("test clock enable done");
      wr(4'h0, 32'h00);
      wait_clk(3);
      chk("raw disabled", 32'h0, {31'h0, raw_o});
      chk("sync disabled", 32'h0, {31'h0, sync_o});
      chk("power disabled", 32'h0, {31'h0, pwr});
      // second reset in mid-run must bring the speed field back
      rst_n <= 1'b0;
      wait_clk(2);
      rst_n <= 1'b1;
      rdchk(4'h4, 32'h02);
      chk("speed after reset", 32'h2, {30'h0, speed});
      $display("test disable done");
      print_verdict;
   end
   initial begin
      #(3000 * 100);
      errors++;
      print_verdict;
   end
endmodule // comparator_edge_event_logic_test
